// ===== design/udma_burst_engine.sv
// Overview of operation
// - Stop strobe edges soon after host not ready
// - Drop DMARQ on STOP, keep it low
// - Raise low strobe on STOP, no data
// - Release data bus when DMARQ drops
// - Capture host CRC on acknowledge negation
// - Compare CRC, report first miscompare per command
// - Release strobe line after acknowledge removed
// - Data-Out starts with device asserting DMARQ
// - Drive ready negated after enable delay, hold
// - Assert ready after STOP release, hold both
// - Pause Data-Out by ready, absorb extras
// - Preset CRC to seed every burst
// - CRC each data strobe edge, skip return
// - CRC error sets interface CRC and abort
`timescale 1ns/1ps
`default_nettype none

module udma_burst_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_in,
  input wire logic start_out,
  input wire logic [2:0] mode,
  input wire logic cmd_done,
  input wire udma_pkg::host_pins_t host_pins,
  output udma_pkg::dev_pins_t dev_pins,
  input wire logic din_valid,
  input wire logic [15:0] din_data,
  output logic din_ready,
  output logic dout_valid,
  input wire logic dout_ready,
  output logic [15:0] dout_data,
  output logic busy,
  output logic [7:0] error_reg
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DI_ACK,
    ST_DI_XFER,
    ST_DO_ACK,
    ST_DO_XFER,
    ST_TERM
  } state_t;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [15:0] word);
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ word[i]) ? ((c << 1) ^ udma_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  udma_pkg::host_pins_t meta_q;
  udma_pkg::host_pins_t sync_q;
  udma_pkg::host_pins_t prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= udma_pkg::HOST_IDLE;
      sync_q <= udma_pkg::HOST_IDLE;
      prev_q <= udma_pkg::HOST_IDLE;
    end else begin
      meta_q <= host_pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic ack_rise;
  logic strobe_edge;
  logic host_rdy;
  assign ack_rise = sync_q.dmack_n && !prev_q.dmack_n;
  assign strobe_edge = sync_q.hstrobe != prev_q.hstrobe;
  // Host ready shares the strobe pin and is active low
  assign host_rdy = !sync_q.hstrobe;

  // ----------------------------------------
  // Burst state and timing
  // ----------------------------------------
  state_t state_q;
  logic [2:0] mode_q;
  logic [7:0] tmr_q;
  logic word_ok_q;
  logic moved_q;
  logic strobe_on_q;
  logic [15:0] crc_q;
  logic crc_bad_q;
  logic push_q;
  logic [15:0] push_data_q;
  logic out_valid_q;
  logic [15:0] out_data_q;
  udma_pkg::dev_pins_t pins_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic [udma_pkg::FIFO_LVL_W-1:0] fifo_level;
  logic room_low;
  logic din_ready_q;

  assign room_low = (fifo_level >= udma_pkg::FIFO_PAUSE_LVL) || !fifo_in_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      mode_q <= 3'h0;
      tmr_q <= 8'h00;
      word_ok_q <= 1'b0;
      moved_q <= 1'b0;
      strobe_on_q <= 1'b0;
      pins_q <= udma_pkg::DEV_IDLE;
      din_ready_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= 16'h0000;
    end else begin
      din_ready_q <= 1'b0;
      push_q <= 1'b0;
      if (tmr_q != 8'h00) begin
        tmr_q <= tmr_q - 8'h01;
      end
      case (state_q)
        ST_IDLE: begin
          pins_q <= udma_pkg::DEV_IDLE;
          word_ok_q <= 1'b0;
          moved_q <= 1'b0;
          strobe_on_q <= 1'b0;
          if (start_in || start_out) begin
            mode_q <= (mode > udma_pkg::MODE_MAX) ? udma_pkg::MODE_MAX : mode;
            pins_q.dmarq <= 1'b1;
            state_q <= start_out ? ST_DO_ACK : ST_DI_ACK;
          end
        end
        ST_DI_ACK: begin
          if (sync_q.dmack_n) begin
            tmr_q <= udma_pkg::ZIORDY_CYC[mode_q];
          end else if (!strobe_on_q && tmr_q == 8'h00) begin
            pins_q.iordy_oe_n <= 1'b0;
            pins_q.iordy <= 1'b1;
            strobe_on_q <= 1'b1;
          end else if (strobe_on_q && !sync_q.stop && host_rdy) begin
            pins_q.dd_oe_n <= 1'b0;
            tmr_q <= udma_pkg::DVS_CYC[mode_q];
            state_q <= ST_DI_XFER;
          end
        end
        ST_DI_XFER: begin
          if (sync_q.stop) begin
            pins_q.dmarq <= 1'b0;
            pins_q.dd_oe_n <= 1'b1;
            pins_q.iordy <= 1'b1;
            state_q <= ST_TERM;
          end else if (!word_ok_q && din_valid && !din_ready_q &&
                       tmr_q <= udma_pkg::DVS_CYC[mode_q]) begin
            pins_q.dd <= din_data;
            word_ok_q <= 1'b1;
            din_ready_q <= 1'b1;
            tmr_q <= udma_pkg::DVS_CYC[mode_q];
          end else if (word_ok_q && tmr_q == 8'h00 && host_rdy) begin
            // Edge only while host ready, so the burst halts on its negation
            pins_q.iordy <= !pins_q.iordy;
            word_ok_q <= 1'b0;
            moved_q <= 1'b1;
            tmr_q <= udma_pkg::CYC_CYC[mode_q];
          end
        end
        ST_DO_ACK: begin
          if (sync_q.dmack_n) begin
            tmr_q <= udma_pkg::ZIORDY_CYC[mode_q];
          end else if (!strobe_on_q && tmr_q == 8'h00) begin
            pins_q.iordy_oe_n <= 1'b0;
            pins_q.iordy <= 1'b1;
            strobe_on_q <= 1'b1;
          end else if (strobe_on_q && !sync_q.stop) begin
            pins_q.iordy <= 1'b0;
            state_q <= ST_DO_XFER;
          end
        end
        ST_DO_XFER: begin
          if (sync_q.stop) begin
            pins_q.dmarq <= 1'b0;
            pins_q.iordy <= 1'b1;
            state_q <= ST_TERM;
          end else begin
            if (strobe_edge) begin
              push_q <= 1'b1;
              push_data_q <= sync_q.dd;
              moved_q <= 1'b1;
            end
            if (moved_q && room_low) begin
              pins_q.iordy <= 1'b1;
            end else if (!room_low) begin
              pins_q.iordy <= 1'b0;
            end
          end
        end
        ST_TERM: begin
          if (ack_rise) begin
            pins_q.iordy_oe_n <= 1'b1;
            pins_q.iordy <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Burst CRC and host CRC check
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= udma_pkg::CRC_SEED;
      crc_bad_q <= 1'b0;
    end else begin
      crc_bad_q <= 1'b0;
      if (state_q == ST_IDLE) begin
        crc_q <= udma_pkg::CRC_SEED;
      end else if (state_q == ST_DI_XFER && !sync_q.stop && word_ok_q &&
                   tmr_q == 8'h00 && host_rdy) begin
        crc_q <= crc_step(crc_q, pins_q.dd);
      end else if (state_q == ST_DO_XFER && !sync_q.stop && strobe_edge) begin
        crc_q <= crc_step(crc_q, sync_q.dd);
      end else if (state_q == ST_TERM && ack_rise) begin
        crc_bad_q <= (sync_q.dd != crc_q);
      end
    end
  end

  // ----------------------------------------
  // First error of a command
  // ----------------------------------------
  logic err_seen_q;
  logic [7:0] error_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_seen_q <= 1'b0;
      error_q <= 8'h00;
    end else if (cmd_done) begin
      error_q <= 8'h00;
      if (err_seen_q || crc_bad_q) begin
        error_q[udma_pkg::ERR_ICRC_BIT] <= 1'b1;
        error_q[udma_pkg::ERR_ABRT_BIT] <= 1'b1;
      end
      err_seen_q <= 1'b0;
    end else if (crc_bad_q) begin
      err_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Data-Out buffer
  // ----------------------------------------
  udma_fifo #(
    .WIDTH(udma_pkg::FIFO_WIDTH),
    .DEPTH(udma_pkg::FIFO_DEPTH),
    .LVL_W(udma_pkg::FIFO_LVL_W)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(fifo_out_valid),
    .out_ready(!out_valid_q || dout_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Output stage, refilled when empty or taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= 16'h0000;
    end else if (!out_valid_q || dout_ready) begin
      out_valid_q <= fifo_out_valid;
      out_data_q <= fifo_out_data;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic busy_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != ST_IDLE) || start_in || start_out;
    end
  end

  assign dev_pins = pins_q;
  assign din_ready = din_ready_q;
  assign dout_valid = out_valid_q;
  assign dout_data = out_data_q;
  assign busy = busy_q;
  assign error_reg = error_q;

endmodule

`default_nettype wire

// ===== inc/udma_pkg.sv
package udma_pkg;

  // ----------------------------------------
  // Clock and interval tables
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int MODES = 5;

  function automatic int ns_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int ns_max(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Per-mode figures in ns, index is the negotiated mode
  localparam int T_CYC_NS[MODES] = '{240, 200, 160, 160, 160};
  localparam int T_DVS_NS[MODES] = '{70, 48, 31, 20, 7};
  localparam int T_DVH_NS[MODES] = '{6, 6, 6, 6, 6};
  localparam int T_ZIORDY_NS[MODES] = '{20, 20, 20, 20, 20};
  localparam int T_RFS_NS[MODES] = '{75, 70, 60, 60, 60};
  localparam int T_SR_NS[MODES] = '{50, 30, 20, 20, 20};
  localparam int T_LI_NS[MODES] = '{150, 150, 150, 100, 100};
  localparam int T_AZ_NS = 10;
  localparam int T_IORDYZ_NS = 20;

  // Derived cycle counts
  localparam logic [7:0] CYC_CYC[MODES] = '{
    8'(ns_min(T_CYC_NS[0])), 8'(ns_min(T_CYC_NS[1])), 8'(ns_min(T_CYC_NS[2])),
    8'(ns_min(T_CYC_NS[3])), 8'(ns_min(T_CYC_NS[4]))};
  localparam logic [7:0] DVS_CYC[MODES] = '{
    8'(ns_min(T_DVS_NS[0])), 8'(ns_min(T_DVS_NS[1])), 8'(ns_min(T_DVS_NS[2])),
    8'(ns_min(T_DVS_NS[3])), 8'(ns_min(T_DVS_NS[4]))};
  localparam logic [7:0] ZIORDY_CYC[MODES] = '{
    8'(ns_min(T_ZIORDY_NS[0])), 8'(ns_min(T_ZIORDY_NS[1])), 8'(ns_min(T_ZIORDY_NS[2])),
    8'(ns_min(T_ZIORDY_NS[3])), 8'(ns_min(T_ZIORDY_NS[4]))};
  localparam int LI_CYC_MODE0 = ns_max(T_LI_NS[0]);
  localparam int AZ_CYC = ns_max(T_AZ_NS);
  localparam int IORDYZ_CYC = ns_max(T_IORDYZ_NS);

  // ----------------------------------------
  // CRC, error bits, buffer
  // ----------------------------------------
  localparam logic [15:0] CRC_SEED = 16'h4ABA;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam int ERR_ICRC_BIT = 7;
  localparam int ERR_ABRT_BIT = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_LVL_W = 6;
  localparam logic [5:0] FIFO_PAUSE_LVL = 6'h1C;
  localparam logic [2:0] MODE_MAX = 3'h4;

  // ----------------------------------------
  // Pin groups
  // ----------------------------------------
  typedef struct packed {
    logic dmack_n;
    logic stop;
    logic hstrobe;
    logic [15:0] dd;
  } host_pins_t;

  typedef struct packed {
    logic dmarq;
    logic iordy;
    logic iordy_oe_n;
    logic [15:0] dd;
    logic dd_oe_n;
  } dev_pins_t;

  localparam host_pins_t HOST_IDLE = '{dmack_n: 1'b1, stop: 1'b0, hstrobe: 1'b1, dd: 16'h0000};
  localparam dev_pins_t DEV_IDLE = '{dmarq: 1'b0, iordy: 1'b1, iordy_oe_n: 1'b1,
                                     dd: 16'h0000, dd_oe_n: 1'b1};

endpackage

// ===== design/udma_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module udma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int LVL_W = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LVL_W-1:0] level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [LVL_W-1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != LVL_W'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign level = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // ----------------------------------------
  // Pointers and fill count
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== dv/udma_burst_engine_properties.sv
`timescale 1ns/1ps
`default_nettype none

module udma_burst_engine_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_done,
  input wire udma_pkg::host_pins_t host_pins,
  input wire udma_pkg::dev_pins_t dev_pins,
  input wire logic [7:0] error_reg
);
  // ------------------------------
  // Link checks
  // ------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  stop_drops_rq_a: assert property ($rose(host_pins.stop) && !host_pins.dmack_n |-> ##[1:4] !dev_pins.dmarq)
    else $error("request not dropped after stop");
  no_rearm_a: assert property (!dev_pins.dmarq && !host_pins.dmack_n |=> !dev_pins.dmarq)
    else $error("request raised inside burst");
  start_idle_a: assert property ($rose(dev_pins.dmarq) |-> host_pins.dmack_n)
    else $error("request raised while acknowledged");
  strobe_parked_a: assert property ($fell(dev_pins.dmarq) |-> dev_pins.iordy)
    else $error("strobe low at request drop");
  strobe_hold_a: assert property (!dev_pins.dmarq && !dev_pins.iordy_oe_n |=> $stable(dev_pins.iordy))
    else $error("strobe moved after termination");
  bus_release_a: assert property (!dev_pins.dmarq |-> dev_pins.dd_oe_n)
    else $error("data bus driven without request");
  strobe_release_a: assert property ($rose(host_pins.dmack_n) |-> ##[1:4] dev_pins.iordy_oe_n)
    else $error("strobe line not released");
  ready_delay_a: assert property ($fell(host_pins.dmack_n) |-> dev_pins.iordy_oe_n [*2])
    else $error("ready line driven too early");
  drive_hold_a: assert property (!dev_pins.iordy_oe_n && !host_pins.dmack_n |=> !dev_pins.iordy_oe_n)
    else $error("ready line released inside burst");
  pause_quiet_a: assert property ((!dev_pins.dd_oe_n && host_pins.hstrobe) [*4] |=> $stable(dev_pins.iordy) || $rose(dev_pins.dd_oe_n))
    else $error("strobe edge while host not ready");
  error_code_a: assert property (cmd_done |=> error_reg == 8'h00 || error_reg == 8'h84)
    else $error("bad error code");
  error_keep_a: assert property (!cmd_done |=> $stable(error_reg))
    else $error("error code changed without command end");

  cover property ($fell(dev_pins.dmarq));
  cover property ($rose(host_pins.dmack_n));
  cover property (cmd_done ##1 error_reg == 8'h84);
endmodule

bind udma_burst_engine udma_burst_engine_properties udma_burst_engine_properties_inst (
  .clk(clk), .rst_n(rst_n), .cmd_done(cmd_done), .host_pins(host_pins),
  .dev_pins(dev_pins), .error_reg(error_reg));

`default_nettype wire

// ===== dv/udma_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module udma_host_model (
  input wire udma_pkg::dev_pins_t dev_pins,
  output udma_pkg::host_pins_t host_pins
);
  logic ack_n = 1'b1;
  logic stp = 1'b0;
  logic hs = 1'b1;
  logic drv = 1'b0;
  logic hung = 1'b0;
  logic [15:0] hdd = 16'h0000;
  logic [15:0] crc = 16'h4ABA;
  logic [15:0] sent[$];
  int cnt = 0;
  // Ready line has a pull-up; released bus shows inverted last value
  wire logic rdy_n = dev_pins.iordy_oe_n | dev_pins.iordy;
  wire logic [15:0] bus = !dev_pins.dd_oe_n ? dev_pins.dd : (drv ? hdd : ~dev_pins.dd);
  assign host_pins = '{dmack_n: ack_n, stop: stp, hstrobe: hs, dd: bus};

  function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] w);
    logic f;
    for (int b = 15; b >= 0; b--) begin
      f = c[15] ^ w[b];
      c = {c[14:0], 1'b0} ^ (f ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction

  function automatic logic ok(input int k);
    case (k)
      0: return dev_pins.dmarq;
      1: return !rdy_n;
      default: return !dev_pins.dmarq;
    endcase
  endfunction

  task automatic wt(input int k);
    int n;
    for (n = 0; n < 20000 && !ok(k) && !hung; n++) #10;
    if (!ok(k)) hung = 1'b1;
  endtask

  // Read words counted on data strobe edges only
  always @(dev_pins.iordy) begin
    #1;
    if (!ack_n && !stp && !dev_pins.dd_oe_n) begin
      crc = step(crc, bus);
      cnt++;
    end
  end

  task automatic burst(input logic out, input int n, input logic bad);
    int i;
    crc = 16'h4ABA;
    cnt = 0;
    wt(0);
    stp = 1'b1;
    hs = 1'b1;
    #100;
    ack_n = 1'b0;
    #120;
    stp = 1'b0;
    if (!out) begin
      hs = 1'b0;
      for (i = 0; i < 20000 && cnt < n && !hung; i++) #10;
      if (cnt < n) hung = 1'b1;
      hs = 1'b1;
      #200;
      stp = 1'b1;
    end else begin
      drv = 1'b1;
      for (i = 0; i < n; i++) begin
        wt(1);
        hdd = 16'($urandom);
        #80;
        wt(1);
        sent.push_back(hdd);
        crc = step(crc, hdd);
        hs = ~hs;
        #80;
      end
      #160;
      stp = 1'b1;
      wt(2);
      #40;
      hs = 1'b1;
    end
    wt(2);
    #120;
    hdd = crc ^ {15'h0000, bad};
    drv = 1'b1;
    #160;
    ack_n = 1'b1;
    #200;
    stp = 1'b0;
    hs = 1'b1;
    drv = 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== dv/test_ultra_dma_burst_engine.sv
`timescale 1ns/1ps
`default_nettype none

module test_ultra_dma_burst_engine;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_in = 1'b0;
  logic start_out = 1'b0;
  logic [2:0] mode = 3'h0;
  logic cmd_done = 1'b0;
  logic din_valid = 1'b0;
  logic [15:0] din_data = 16'h0000;
  logic dout_ready = 1'b0;
  logic stall = 1'b0;
  logic done_q = 1'b0;
  logic pi = 1'b1;
  udma_pkg::host_pins_t host_pins;
  udma_pkg::dev_pins_t dev_pins;
  logic din_ready;
  logic dout_valid;
  logic busy;
  logic [15:0] dout_data;
  logic [7:0] error_reg;
  logic [15:0] q_in[$];
  logic [7:0] q_err[$];
  int num_errors = 0;
  int checks = 0;

  always #20 clk = ~clk;

  udma_burst_engine udma_burst_engine_inst (.clk(clk), .rst_n(rst_n), .start_in(start_in),
    .start_out(start_out), .mode(mode), .cmd_done(cmd_done), .host_pins(host_pins),
    .dev_pins(dev_pins), .din_valid(din_valid), .din_data(din_data), .din_ready(din_ready),
    .dout_valid(dout_valid), .dout_ready(dout_ready), .dout_data(dout_data), .busy(busy),
    .error_reg(error_reg));
  udma_host_model udma_host_model_inst (.dev_pins(dev_pins), .host_pins(host_pins));

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_err(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value error_reg expected %h seen %h", exp, got);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------
  // Word source and sink
  // ------------------------------
  always @(posedge clk) begin
    #1;
    if (din_ready === 1'b1) begin
      q_in.push_back(din_data);
      din_data = 16'($urandom);
    end
    dout_ready = !stall && 1'($urandom);
  end

  always @(posedge clk) begin
    if (dev_pins.iordy !== pi && dev_pins.dd_oe_n === 1'b0)
      chk_word("read word", q_in.size() ? q_in.pop_front() : 16'hXXXX, dev_pins.dd);
    pi <= dev_pins.iordy;
    if (dout_valid === 1'b1 && dout_ready === 1'b1)
      chk_word("write word", udma_host_model_inst.sent.size() ?
        udma_host_model_inst.sent.pop_front() : 16'hXXXX, dout_data);
    if (done_q) chk_err(q_err.pop_front(), error_reg);
    done_q <= cmd_done;
  end

  // ------------------------------
  // Sequences
  // ------------------------------
  task automatic run(input logic out, input int n, input logic bad);
    @(posedge clk);
    #1;
    start_in = !out;
    start_out = out;
    din_valid = !out;
    stall = out;
    @(posedge clk);
    #1;
    start_in = 1'b0;
    start_out = 1'b0;
    chk_word("request", 16'h0001, {15'h0000, dev_pins.dmarq});
    chk_word("busy", 16'h0001, {15'h0000, busy});
    fork
      udma_host_model_inst.burst(out, n, bad);
      begin
        repeat (250) @(posedge clk);
        #1;
        stall = 1'b0;
      end
    join
    @(posedge clk);
    #1;
    din_valid = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk_word("busy", 16'h0000, {15'h0000, busy});
    q_in.delete();
    if (udma_host_model_inst.hung) begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic cmd_end(input logic [7:0] exp);
    @(posedge clk);
    #1;
    q_err.push_back(exp);
    cmd_done = 1'b1;
    @(posedge clk);
    #1;
    cmd_done = 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    int m;
    void'($urandom(32'h0B05));
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (m = 0; m < 6; m++) begin
      mode = (m == 5) ? 3'h7 : 3'(m);
      run(1'b0, 2 + int'($urandom % 4), 1'b0);
      cmd_end(8'h00);
    end
    mode = 3'h4;
    run(1'b1, 41, 1'b1);
    run(1'b0, 3, 1'b0);
    cmd_end(8'h84);
    cmd_end(8'h00);
    repeat (100) @(posedge clk);
    chk_word("words left", 16'h0000, 16'(udma_host_model_inst.sent.size()));
    summarize();
  end
endmodule

`default_nettype wire
